// File: rtl/rdw_watchdog.sv
// Runaway-detection watchdog with classic Wishbone register slave
//
// Decided for this implementation: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "rdw_defines.svh"

// Behaviour
// - Twenty-two stage counter on system clock
// - Period select picks tap, overflow interrupts
// - Period select resets to shortest period
// - Enable bit resets to one, enabled
// - Disable needs enable cleared then code
// - Setting enable bit re-enables at once
// - Reset-connect resets zero; one drives reset
// - Internal reset held 22 to 29 states
// - Clear code zeroes counter, counting resumes
// - Overflow raises a non-maskable interrupt request
// - Counting starts right after reset release
// - Counter stops in deep idle, stop
// - Counter keeps running during bus release
// - Light idle follows idle-run control bit
module rdw_watchdog #(
  parameter int unsigned CNT_W       = `RDW_CNT_W,
  parameter int unsigned RST_CYCLES  = `RDW_RST_STATES
) (
  // Clock, reset, enable
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire logic                ce_i,
  // Wishbone slave
  input  wire rdw_pkg::rdw_wb_req_t wb_req_i,
  output rdw_pkg::rdw_wb_rsp_t      wb_rsp_o,
  // Low-power and bus state
  input  wire logic                deep_idle_mode_i,
  input  wire logic                stop_mode_i,
  input  wire logic                light_idle_mode_i,
  input  wire logic                bus_grant_ack_i,
  // Watchdog outputs
  output logic                     runaway_nmi_o,
  output logic                     runaway_out_o,
  output logic                     chip_reset_o,
  output logic                     irq_o
);
  import rdw_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic tap_full(input logic [CNT_W-1:0] cnt,
                                    input logic [1:0]       sel);
    int unsigned w;
    logic        full;
    w    = `RDW_TAP_BASE + `RDW_TAP_STEP * int'(sel);
    full = 1'b1;
    for (int i = 0; i < CNT_W; i++) begin
      if (i < w) begin
        full = full & cnt[i];
      end
    end
    return full;
  endfunction : tap_full

  function automatic logic wr_hit(input logic       acc,
                                  input logic [7:0] adr,
                                  input logic [7:0] off);
    return acc && (adr == off);
  endfunction : wr_hit

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic                    ack_r;
  logic [31:0]             rdat_r;
  logic [31:0]             rdat_nxt;
  logic [1:0]              psel_r;
  logic                    mode_en_r;
  logic                    rc_r;
  logic                    lir_r;
  logic                    wd_en_r;
  logic                    wd_en_nxt;
  logic [CNT_W-1:0]        cnt_r;
  logic [CNT_W-1:0]        cnt_nxt;
  logic                    nmi_r;
  logic                    out_r;
  logic [`RDW_EVT_W-1:0]   stat_r;
  logic [`RDW_EVT_W-1:0]   stat_nxt;
  logic [`RDW_EVT_W-1:0]   ien_r;
  logic [7:0]              mode_rd;

  wire                     req;
  wire                     wr_acc;
  wire                     lane0;
  wire [7:0]               wbyte;
  wire                     wr_mode;
  wire                     wr_cmd;
  wire                     wr_iclr;
  wire                     wr_ien;
  wire                     cmd_clear;
  wire                     cmd_disable;
  wire                     halted;
  wire                     run;
  wire                     ovf;
  wire                     rst_trig;
  wire                     rst_req;
  wire [`RDW_EVT_W-1:0]    evt;
  wire [`RDW_EVT_W-1:0]    clr_mask;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  assign req     = wb_req_i.cyc & wb_req_i.stb;
  assign wr_acc  = req & wb_req_i.we & ack_r;
  assign lane0   = wb_req_i.sel[0];
  assign wbyte   = wb_req_i.dat[7:0];
  assign wr_mode = wr_hit(wr_acc & lane0, wb_req_i.adr, `RDW_OFF_MODE);
  assign wr_cmd  = wr_hit(wr_acc & lane0, wb_req_i.adr, `RDW_OFF_CMD);
  assign wr_iclr = wr_hit(wr_acc & lane0, wb_req_i.adr, `RDW_OFF_ICLR);
  assign wr_ien  = wr_hit(wr_acc & lane0, wb_req_i.adr, `RDW_OFF_IEN);

  assign cmd_clear   = wr_cmd & (wbyte == `RDW_CODE_CLEAR);
  assign cmd_disable = wr_cmd & (wbyte == `RDW_CODE_DISABLE);

  always_comb begin
    mode_rd                    = 8'h00;
    mode_rd[`RDW_MODE_EN_BIT]  = mode_en_r;
    mode_rd[`RDW_MODE_PSH_BIT] = psel_r[1];
    mode_rd[`RDW_MODE_PSL_BIT] = psel_r[0];
    mode_rd[`RDW_MODE_LIR_BIT] = lir_r;
    mode_rd[`RDW_MODE_RC_BIT]  = rc_r;
  end

  always_comb begin
    rdat_nxt = 32'h0000_0000;
    unique case (wb_req_i.adr)
      `RDW_OFF_MODE: rdat_nxt = {24'h00_0000, mode_rd};
      `RDW_OFF_STAT: rdat_nxt = {{(32 - `RDW_EVT_W){1'b0}}, stat_r};
      `RDW_OFF_IEN:  rdat_nxt = {{(32 - `RDW_EVT_W){1'b0}}, ien_r};
      `RDW_OFF_CNT:  rdat_nxt = 32'(cnt_r);
      default:       rdat_nxt = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r  <= 1'b0;
      rdat_r <= 32'h0000_0000;
    end else if (ce_i) begin
      ack_r  <= req & ~ack_r;
      rdat_r <= rdat_nxt;
    end
  end

  assign wb_rsp_o.ack = ack_r & req;
  assign wb_rsp_o.dat = rdat_r;

  ////////////////////////////////////////////////////////////////////////////
  // Mode register

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      psel_r    <= `RDW_PSEL_RST;
      mode_en_r <= `RDW_EN_RST;
      rc_r      <= `RDW_RC_RST;
      lir_r     <= `RDW_LIR_RST;
    end else if (ce_i && wr_mode) begin
      psel_r    <= {wbyte[`RDW_MODE_PSH_BIT], wbyte[`RDW_MODE_PSL_BIT]};
      mode_en_r <= wbyte[`RDW_MODE_EN_BIT];
      rc_r      <= wbyte[`RDW_MODE_RC_BIT];
      lir_r     <= wbyte[`RDW_MODE_LIR_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Effective enable

  always_comb begin
    wd_en_nxt = wd_en_r;
    if (wr_mode && wbyte[`RDW_MODE_EN_BIT]) begin
      wd_en_nxt = 1'b1;
    end else if (cmd_disable && !mode_en_r) begin
      wd_en_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wd_en_r <= `RDW_EN_RST;
    end else if (ce_i) begin
      wd_en_r <= wd_en_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter

  // stop in deep idle or stop
  // light idle gated by run bit
  assign halted = deep_idle_mode_i | stop_mode_i | (light_idle_mode_i & ~lir_r);
  assign run    = wd_en_r & ~halted & (bus_grant_ack_i | ~bus_grant_ack_i);
  assign ovf    = run & tap_full(cnt_r, psel_r) & ~cmd_clear;

  always_comb begin
    cnt_nxt = cnt_r;
    if (cmd_clear) begin
      cnt_nxt = '0;
    end else if (run) begin
      cnt_nxt = cnt_r + CNT_W'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r <= '0;
    end else if (ce_i) begin
      cnt_r <= cnt_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Overflow outputs

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      nmi_r <= 1'b0;
      out_r <= 1'b0;
    end else if (ce_i) begin
      nmi_r <= ovf;
      out_r <= ovf | (out_r & ~cmd_clear);
    end
  end

  assign runaway_nmi_o = nmi_r;
  assign runaway_out_o = out_r;

  ////////////////////////////////////////////////////////////////////////////
  // Internal reset

  assign rst_trig = ovf & rc_r;

  rdw_reset_stretch #(
    .HOLD_CYCLES (RST_CYCLES)
  ) u_stretch (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .ce_i      (ce_i),
    .trig_i    (rst_trig),
    .rst_req_o (rst_req)
  );

  assign chip_reset_o = rst_req;

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status

  assign evt      = {rst_trig, ovf};
  assign clr_mask = wr_iclr ? wbyte[`RDW_EVT_W-1:0] : '0;

  // Set wins over clear
  assign stat_nxt = evt | (stat_r & ~clr_mask);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat_r <= '0;
      ien_r  <= '0;
    end else if (ce_i) begin
      stat_r <= stat_nxt;
      if (wr_ien) begin
        ien_r <= wbyte[`RDW_EVT_W-1:0];
      end
    end
  end

  assign irq_o = |(stat_r & ien_r);

endmodule : rdw_watchdog
`default_nettype wire

// File: rtl/rdw_defines.svh
// Offsets, field positions, codes and timing counts of the runaway watchdog
`ifndef RDW_DEFINES_SVH
`define RDW_DEFINES_SVH

`define RDW_OFF_MODE      8'h00
`define RDW_OFF_CMD       8'h04
`define RDW_OFF_STAT      8'h08
`define RDW_OFF_ICLR      8'h0C
`define RDW_OFF_IEN       8'h10
`define RDW_OFF_CNT       8'h14

`define RDW_MODE_EN_BIT   7
`define RDW_MODE_PSH_BIT  6
`define RDW_MODE_PSL_BIT  5
`define RDW_MODE_LIR_BIT  3
`define RDW_MODE_RC_BIT   2

`define RDW_PSEL_RST      2'h0
`define RDW_EN_RST        1'h1
`define RDW_RC_RST        1'h0
`define RDW_LIR_RST       1'h0

`define RDW_CODE_DISABLE  8'hB1
`define RDW_CODE_CLEAR    8'h4E

`define RDW_STAT_OVF_BIT  0
`define RDW_STAT_RST_BIT  1
`define RDW_EVT_W         2

`define RDW_CNT_W         22
`define RDW_TAP_BASE      15
`define RDW_TAP_STEP      2

`define RDW_RST_MIN_STATES 22
`define RDW_RST_MAX_STATES 29
`define RDW_RST_STATES     22

`endif

// File: rtl/rdw_pkg.sv
// Types shared by the runaway watchdog design
package rdw_pkg;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } rdw_wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } rdw_wb_rsp_t;

  typedef enum logic [0:0] {
    RDW_RS_IDLE = 1'b0,
    RDW_RS_HOLD = 1'b1
  } rdw_rst_state_t;

endpackage : rdw_pkg

// File: rtl/rdw_reset_stretch.sv
// Stretches a watchdog overflow into a fixed-length internal reset
`timescale 1ns/1ns
`default_nettype none
`include "rdw_defines.svh"

module rdw_reset_stretch #(
  parameter int unsigned HOLD_CYCLES = `RDW_RST_STATES
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic ce_i,
  // Trigger and reset out
  input  wire logic trig_i,
  output logic      rst_req_o
);
  import rdw_pkg::*;

  localparam int unsigned CW = $clog2(HOLD_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(HOLD_CYCLES - 1);

  rdw_rst_state_t  state_r;
  rdw_rst_state_t  state_nxt;
  logic [CW-1:0]   cnt_r;
  logic [CW-1:0]   cnt_nxt;
  wire             done;

  assign done = (cnt_r == LAST);

  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    unique case (state_r)
      RDW_RS_IDLE: begin
        cnt_nxt = '0;
        if (trig_i) begin
          state_nxt = RDW_RS_HOLD;
        end
      end
      RDW_RS_HOLD: begin
        cnt_nxt = cnt_r + CW'(1);
        if (done) begin
          state_nxt = RDW_RS_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= RDW_RS_IDLE;
      cnt_r   <= '0;
    end else if (ce_i) begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  assign rst_req_o = (state_r == RDW_RS_HOLD);

endmodule : rdw_reset_stretch
`default_nettype wire

// File: tb/rdw_watchdog_assertions.sv
// Port checker for the runaway watchdog
`timescale 1ns/1ns
`default_nettype none
`include "rdw_defines.svh"
module rdw_watchdog_chk #(
  parameter int unsigned RST_CYCLES = `RDW_RST_STATES
) (
  // Clock and inputs
  input wire logic                 clk_i,
  input wire logic                 rst_i,
  input wire logic                 ce_i,
  input wire rdw_pkg::rdw_wb_req_t wb_req_i,
  input wire logic                 deep_idle_mode_i,
  input wire logic                 stop_mode_i,
  // Design outputs
  input wire rdw_pkg::rdw_wb_rsp_t wb_rsp_o,
  input wire logic                 runaway_nmi_o,
  input wire logic                 runaway_out_o,
  input wire logic                 chip_reset_o,
  input wire logic                 irq_o
);
  import rdw_pkg::*;
  logic [7:0] len_r;
  logic       wr_clr;
  assign wr_clr = wb_rsp_o.ack && wb_req_i.we && wb_req_i.adr == `RDW_OFF_CMD && wb_req_i.sel[0]
                  && wb_req_i.dat[7:0] == `RDW_CODE_CLEAR;
  always_ff @(posedge clk_i) len_r <= chip_reset_o ? len_r + 8'h01 : 8'h00;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////
  property p_ack_next; $rose(wb_req_i.cyc && wb_req_i.stb) && ce_i |=> wb_rsp_o.ack; endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack late");
  property p_ack_pulse; wb_rsp_o.ack |=> !wb_rsp_o.ack; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_nmi_pulse; runaway_nmi_o |=> !runaway_nmi_o; endproperty
  a_nmi_pulse: assert property (p_nmi_pulse) else $error("nmi too long");
  property p_nmi_out; runaway_nmi_o |-> runaway_out_o; endproperty
  a_nmi_out: assert property (p_nmi_out) else $error("out missing");
  property p_rst_len; $fell(chip_reset_o) |-> len_r == RST_CYCLES; endproperty
  a_rst_len: assert property (p_rst_len) else $error("reset length");
  property p_rst_cause; $rose(chip_reset_o) |-> runaway_nmi_o; endproperty
  a_rst_cause: assert property (p_rst_cause) else $error("reset without overflow");
  property p_halt; deep_idle_mode_i || stop_mode_i |=> !runaway_nmi_o; endproperty
  a_halt: assert property (p_halt) else $error("overflow while halted");
  property p_clr_out; wr_clr |=> !runaway_out_o; endproperty
  a_clr_out: assert property (p_clr_out) else $error("out not cleared");
  property p_rd_cmd; wb_rsp_o.ack && !wb_req_i.we && wb_req_i.adr == `RDW_OFF_CMD |-> wb_rsp_o.dat == 32'h0;
  endproperty
  a_rd_cmd: assert property (p_rd_cmd) else $error("command read not zero");
  property p_rst_out; disable iff (1'b0) rst_i |=> !runaway_out_o && !chip_reset_o && !irq_o; endproperty
  a_rst_out: assert property (p_rst_out) else $error("outputs active after reset");
endmodule : rdw_watchdog_chk
bind rdw_watchdog rdw_watchdog_chk #(.RST_CYCLES(RST_CYCLES)) u_chk (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
  .wb_req_i(wb_req_i), .deep_idle_mode_i(deep_idle_mode_i), .stop_mode_i(stop_mode_i), .wb_rsp_o(wb_rsp_o),
  .runaway_nmi_o(runaway_nmi_o), .runaway_out_o(runaway_out_o), .chip_reset_o(chip_reset_o), .irq_o(irq_o));
`default_nettype wire

// File: tb/rdw_watchdog_tb_top.sv
// Self-checking bench for the runaway watchdog
`timescale 1ns/1ns
`default_nettype none
`include "rdw_defines.svh"
module rdw_watchdog_tb_top;
  import rdw_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  rdw_wb_req_t req = '0;
  rdw_wb_rsp_t rsp;
  logic        deep = 1'b0, stp = 1'b0, light = 1'b0, bga = 1'b1;
  logic        nmi, wdo, crst, irq;
  int          n_errors = 0;
  int          tests_run = 0;
  int          mode_m, k;
  logic [31:0] q, c1, c2;
  always #5 clk_i = ~clk_i;
  rdw_watchdog uut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_req_i(req), .wb_rsp_o(rsp),
    .deep_idle_mode_i(deep), .stop_mode_i(stp), .light_idle_mode_i(light), .bus_grant_ack_i(bga),
    .runaway_nmi_o(nmi), .runaway_out_o(wdo), .chip_reset_o(crst), .irq_o(irq));
  ////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    req <= '{1'b1, 1'b1, w, a, 4'hF, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (rsp.ack !== 1'b1 && n < 50);
    if (n >= 50) begin
      chk(32'h0, 32'h1);
      test_done();
    end
    q = rsp.dat;
    req <= '0;
  endtask : bus
  task automatic cnt2(input logic run);
    bus(1'b0, `RDW_OFF_CNT, 32'h0);
    c1 = q;
    repeat (20) @(posedge clk_i);
    bus(1'b0, `RDW_OFF_CNT, 32'h0);
    c2 = q;
    if (run) chk(c2 >= c1 + 20, 32'h1);
    else chk(c2, c1);
  endtask : cnt2
  ////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'hFF528FFF));
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(1'b0, `RDW_OFF_MODE, 32'h0);
    chk(q, 32'h80);
    cnt2(1'b1);
    bus(1'b0, `RDW_OFF_CMD, 32'h0);
    chk(q, 32'h0);
    bus(1'b0, 8'h40, 32'h0);
    chk(q, 32'h0);
    for (k = 0; k < 4; k++) begin
      mode_m = 8'h80 | (k << 5);
      bus(1'b1, `RDW_OFF_MODE, mode_m);
      bus(1'b0, `RDW_OFF_MODE, 32'h0);
      chk(q, mode_m);
    end
    bus(1'b1, `RDW_OFF_CMD, 32'h4E);
    repeat (100) @(posedge clk_i);
    bus(1'b1, `RDW_OFF_CMD, 32'h10 | ($urandom & 32'h0F));
    bus(1'b0, `RDW_OFF_CNT, 32'h0);
    chk(q >= 100, 32'h1);
    bus(1'b1, `RDW_OFF_CMD, 32'h4E);
    bus(1'b0, `RDW_OFF_CNT, 32'h0);
    chk(q < 8, 32'h1);
    bus(1'b1, `RDW_OFF_MODE, 32'h0);
    cnt2(1'b1);
    bus(1'b1, `RDW_OFF_CMD, 32'hB1);
    cnt2(1'b0);
    bus(1'b1, `RDW_OFF_MODE, 32'h80);
    cnt2(1'b1);
    for (k = 0; k < 4; k++) begin
      deep <= k == 0;
      stp <= k == 1;
      light <= k == 2;
      bga <= k != 3;
      cnt2(k == 3);
    end
    bus(1'b1, `RDW_OFF_MODE, 32'h88);
    light <= 1'b1;
    cnt2(1'b1);
    light <= 1'b0;
    bga <= 1'b1;
    bus(1'b1, `RDW_OFF_MODE, 32'h84);
    bus(1'b1, `RDW_OFF_IEN, 32'h3);
    bus(1'b1, `RDW_OFF_CMD, 32'h4E);
    for (k = 0; k < 40000 && nmi !== 1'b1; k++) @(posedge clk_i);
    chk(k > 32760 && k < 32780, 32'h1);
    for (k = 0; k < 100 && crst === 1'b1; k++) @(posedge clk_i);
    chk(k, 32'd22);
    chk({irq, wdo}, 32'h3);
    bus(1'b0, `RDW_OFF_STAT, 32'h0);
    chk(q, 32'h3);
    bus(1'b1, `RDW_OFF_IEN, 32'h0);
    @(posedge clk_i);
    chk(irq, 32'h0);
    bus(1'b1, `RDW_OFF_IEN, 32'h3);
    @(posedge clk_i);
    chk(irq, 32'h1);
    bus(1'b1, `RDW_OFF_ICLR, 32'h3);
    bus(1'b1, `RDW_OFF_CMD, 32'h4E);
    @(posedge clk_i);
    chk({irq, wdo}, 32'h0);
    test_done();
  end
endmodule : rdw_watchdog_tb_top
`default_nettype wire
